// [common/dbg_seq_pkg.sv]
/*
 * Shared constants and types of the debug state sequencer: register indexes
 * and byte addresses, control fields, window codes, sequencer states,
 * per-channel destinations.
 * Assumes a 32-bit APB with byte addresses; each register is one aligned word.
 */
package dbg_seq_pkg;

    // bus geometry
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;

    // register indexes; byte address is four times the index
    localparam logic [7:0] IDX_CONTROL = 8'h20;
    localparam logic [7:0] IDX_STATUS = 8'h21;
    localparam logic [7:0] IDX_SHARED = 8'h27;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = {2'h0, IDX_CONTROL, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_SHARED = {2'h0, IDX_SHARED, 2'h0};

    // debug_control_one fields
    localparam int unsigned CTL_ARM_BIT = 7;
    localparam int unsigned CTL_WIN_LSB = 0;
    localparam int unsigned WIN_W = 2;

    // window_select codes for the shared address
    localparam logic [WIN_W-1:0] WIN_SCR1 = 2'h0;
    localparam logic [WIN_W-1:0] WIN_SCR2 = 2'h1;
    localparam logic [WIN_W-1:0] WIN_SCR3 = 2'h2;
    localparam logic [WIN_W-1:0] WIN_FLAGS = 2'h3;

    // channel and code sizes, reset values
    localparam int unsigned NCH = 3;
    localparam int unsigned CODE_W = 4;
    localparam logic [CODE_W-1:0] CODE_RST = 4'h0;
    localparam logic [NCH-1:0] FLAGS_RST = 3'h0;
    localparam logic [WIN_W-1:0] WIN_RST = 2'h0;

    // where a matching channel sends the sequencer
    typedef logic [2:0] dest_t;
    localparam dest_t D_NONE = 3'h0;
    localparam dest_t D_S1 = 3'h1;
    localparam dest_t D_S2 = 3'h2;
    localparam dest_t D_S3 = 3'h3;
    localparam dest_t D_FIN = 3'h4;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_ONE = 5'h02,
        ST_TWO = 5'h04,
        ST_THREE = 5'h08,
        ST_FINAL = 5'h10
    } seq_state_t;

    typedef struct packed {
        logic arm;
        logic [WIN_W-1:0] window_select;
    } control_t;

endpackage

// [design/debug_state_sequencer.sv]
/*
 * Debug state sequencer: APB register slave with banked state control
 * registers behind one shared address, match flag register, arm control
 * and the State1..State3/Final sequencer.
 * Assumes channel_match comes from comparator logic on pclk, one cycle pulses
 * or levels, already qualified by the comparator enables.
 */
// Chosen here: the APB register port.
`timescale 1ns/1ps
// Functional notes
// - four registers banked at one address
// - control code writes only when disarmed
// - flags visible at window three, read-only
// - code in bits three to zero
// - State1 codes zero to three transitions
// - State1 codes four to seven transitions
// - State1 codes nine, thirteen; others reserved
// - unnamed channel match causes nothing
// - final first, then lowest channel wins
// - State2 codes zero to three transitions
// - State2 codes four to seven transitions
// - State2 codes twelve, fifteen; others reserved
// - State3 codes zero to three transitions
// - State3 codes four to seven transitions
// - State3 codes ten, thirteen, fourteen; rest reserved
// - one sticky flag per match channel
// - flags cleared only by arming write
// - flags independent; repeats change nothing
// - window select lives in control register
module debug_state_sequencer
    import dbg_seq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NCH-1:0] channel_match,
    output seq_state_t seq_state,
    output logic session_armed,
    output logic [NCH-1:0] match_flags
);

    control_t control;
    logic [CODE_W-1:0] next_select [NCH];
    seq_state_t dec_next;

    // bus phase decode
    wire access = psel && penable;
    wire first_access = access && !pready;
    wire commit = access && pready;
    wire wr = commit && pwrite && pstrb[0];

    // address decode
    wire hit_ctl = (paddr == ADDR_CONTROL);
    wire hit_stat = (paddr == ADDR_STATUS);
    wire hit_shared = (paddr == ADDR_SHARED);
    wire mapped = hit_ctl || hit_stat || hit_shared;

    // write strobes
    wire ctl_wr = wr && hit_ctl;
    wire arm_wr = ctl_wr && pwdata[CTL_ARM_BIT];
    wire code_wr_ok = wr && hit_shared && !control.arm;
    wire [WIN_W-1:0] win = control.window_select;

    // sequencer qualification
    wire sequencing = control.arm &&
        (seq_state == ST_ONE || seq_state == ST_TWO || seq_state == ST_THREE);
    wire [CODE_W-1:0] cur_code = (seq_state == ST_TWO) ? next_select[1] :
                                 (seq_state == ST_THREE) ? next_select[2] :
                                 next_select[0];
    wire reach_final = sequencing && (dec_next == ST_FINAL);

    // flag update: arming clears, a session match sets, set wins
    wire [NCH-1:0] flags_base = arm_wr ? FLAGS_RST : match_flags;
    wire [NCH-1:0] flags_set = sequencing ? channel_match : FLAGS_RST;
    wire [NCH-1:0] next_flags = flags_base | flags_set;

    // read data selection; window three shows flags, others a code
    wire [DATA_W-1:0] flags_word = {29'h0, match_flags};
    wire [CODE_W-1:0] win_code = (win == WIN_SCR2) ? next_select[1] :
                                 (win == WIN_SCR3) ? next_select[2] : next_select[0];
    wire [DATA_W-1:0] code_word = {28'h0, win_code};
    wire [DATA_W-1:0] shared_word = (win == WIN_FLAGS) ? flags_word : code_word;
    wire [DATA_W-1:0] ctl_word = {24'h0, control.arm, 5'h0, control.window_select};
    wire [DATA_W-1:0] stat_word = {27'h0, seq_state};
    wire [DATA_W-1:0] rd_word = hit_ctl ? ctl_word :
                                hit_stat ? stat_word :
                                hit_shared ? shared_word : 32'h0;

    next_state_decoder u_decoder (
        .state(seq_state),
        .code(cur_code),
        .match(channel_match),
        .next_state(dec_next)
    );

    // apb answer: ready on the second access cycle, data and error with it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready <= first_access;
            pslverr <= first_access && !mapped;
            if (first_access && !pwrite) prdata <= rd_word;
        end
    end

    // banked next-state code registers, one each for State1 to State3
    genvar i;
    generate
        for (i = 0; i < NCH; i++) begin : g_code
            wire sel_me = code_wr_ok && (win == WIN_W'(i));
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) next_select[i] <= CODE_RST;
                else if (sel_me) next_select[i] <= pwdata[CODE_W-1:0];
            end
        end
    endgenerate

    // control register; reaching final ends the session
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control.arm <= 1'b0;
            control.window_select <= WIN_RST;
        end else if (ctl_wr) begin
            control.arm <= pwdata[CTL_ARM_BIT];
            control.window_select <= pwdata[CTL_WIN_LSB +: WIN_W];
        end else if (reach_final) begin
            control.arm <= 1'b0;
        end
    end

    // sequencer state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) seq_state <= ST_IDLE;
        else if (arm_wr) seq_state <= ST_ONE;
        else if (sequencing) seq_state <= dec_next;
    end

    // sticky match flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) match_flags <= FLAGS_RST;
        else match_flags <= next_flags;
    end

    assign session_armed = control.arm;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // shared address with window three answers with the flags
    property p_window_flags;
        first_access && !pwrite && hit_shared && win == WIN_FLAGS
            |=> pready && prdata == {29'h0, $past(match_flags)};
    endproperty
    a_window_flags: assert property (p_window_flags)
        else $error("flag window read returned wrong data");

    // window zero answers with the State1 code
    property p_window_code;
        first_access && !pwrite && hit_shared && win == WIN_SCR1
            |=> prdata == {28'h0, $past(next_select[0])};
    endproperty
    a_window_code: assert property (p_window_code)
        else $error("code window read returned wrong data");

    // armed: code writes are dropped
    property p_locked_write;
        wr && hit_shared && control.arm
            |=> next_select[0] == $past(next_select[0])
                && next_select[1] == $past(next_select[1])
                && next_select[2] == $past(next_select[2]);
    endproperty
    a_locked_write: assert property (p_locked_write)
        else $error("code register changed while armed");

    // a session match raises its flag
    property p_flag_set;
        sequencing && !arm_wr
            |=> (match_flags & $past(channel_match)) == $past(channel_match);
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("match did not set its flag");

    // arming while disarmed clears flags
    property p_flag_clear;
        arm_wr && !control.arm |=> match_flags == FLAGS_RST;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("flags not cleared by arming");

    // outside a session nothing moves the flags
    property p_flag_idle;
        !arm_wr && !sequencing |=> match_flags == $past(match_flags);
    endproperty
    a_flag_idle: assert property (p_flag_idle)
        else $error("flags changed outside a session");

    // set flags stay set until the next arming
    property p_flag_sticky;
        !arm_wr |=> (match_flags & $past(match_flags)) == $past(match_flags);
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("flag dropped without arming");

    // arming starts in State1 and the session is live
    property p_arm_start;
        arm_wr |=> seq_state == ST_ONE && session_armed;
    endproperty
    a_arm_start: assert property (p_arm_start)
        else $error("arming did not start State1");

    // no match, no move
    property p_no_match_hold;
        sequencing && channel_match == FLAGS_RST && !arm_wr
            |=> seq_state == $past(seq_state);
    endproperty
    a_no_match_hold: assert property (p_no_match_hold)
        else $error("state moved without a match");

    // reserved State1 code ignores all matches
    property p_reserved_hold;
        sequencing && seq_state == ST_ONE && next_select[0] == 4'h8 && !arm_wr
            |=> seq_state == ST_ONE;
    endproperty
    a_reserved_hold: assert property (p_reserved_hold)
        else $error("reserved code caused a transition");

    // State1 code 1101 with match0 and match1 together goes final and disarms
    property p_final_priority;
        sequencing && seq_state == ST_ONE && next_select[0] == 4'hD
            && channel_match == 3'h3 && !ctl_wr
            |=> seq_state == ST_FINAL && !session_armed;
    endproperty
    a_final_priority: assert property (p_final_priority)
        else $error("final did not take priority");

    // State2 code 0100: match1 goes to State1
    property p_state2_move;
        sequencing && seq_state == ST_TWO && next_select[1] == 4'h4
            && channel_match == 3'h2 && !arm_wr
            |=> seq_state == ST_ONE;
    endproperty
    a_state2_move: assert property (p_state2_move)
        else $error("State2 code 0100 wrong transition");

    // State3 code 1110: match0 goes to State2
    property p_state3_move;
        sequencing && seq_state == ST_THREE && next_select[2] == 4'hE
            && channel_match == 3'h1 && !arm_wr
            |=> seq_state == ST_TWO;
    endproperty
    a_state3_move: assert property (p_state3_move)
        else $error("State3 code 1110 wrong transition");

    // State1 code 0001: a match on channel one goes to State3
    property p_state1_move;
        sequencing && seq_state == ST_ONE && next_select[0] == 4'h1
            && channel_match[1] && !arm_wr
            |=> seq_state == ST_THREE;
    endproperty
    a_state1_move: assert property (p_state1_move)
        else $error("State1 code 0001 wrong transition");

    // an unmapped access answers with an error
    property p_unmapped_err;
        first_access && !mapped |=> pready && pslverr;
    endproperty
    a_unmapped_err: assert property (p_unmapped_err)
        else $error("unmapped access gave no error");

    // a write at the flag window leaves every code alone
    property p_flags_window_write;
        wr && hit_shared && win == WIN_FLAGS
            |=> next_select[0] == $past(next_select[0])
                && next_select[1] == $past(next_select[1])
                && next_select[2] == $past(next_select[2]);
    endproperty
    a_flags_window_write: assert property (p_flags_window_write)
        else $error("flag window write changed a code");

    // reaching final ends the session
    property p_final_disarm;
        reach_final && !ctl_wr |=> seq_state == ST_FINAL && !session_armed;
    endproperty
    a_final_disarm: assert property (p_final_disarm)
        else $error("final did not end the session");

    // final holds until the next arming
    property p_final_hold;
        seq_state == ST_FINAL && !arm_wr |=> seq_state == ST_FINAL;
    endproperty
    a_final_hold: assert property (p_final_hold)
        else $error("final left without arming");

    // disarmed, the sequencer stays frozen
    property p_disarmed_hold;
        !control.arm && !arm_wr |=> seq_state == $past(seq_state);
    endproperty
    a_disarmed_hold: assert property (p_disarmed_hold)
        else $error("state moved while disarmed");

    // every access is answered one cycle later, for one cycle
    property p_ready_once;
        first_access |=> pready ##1 !pready;
    endproperty
    a_ready_once: assert property (p_ready_once)
        else $error("bus answer timing wrong");

endmodule

// [design/next_state_decoder.sv]
/*
 * Next-state decoder: per-state code table to per-channel destinations,
 * then final-first, lowest-channel-next priority.
 * Assumes state, code and matches are stable within one pclk cycle.
 */
`timescale 1ns/1ps
module next_state_decoder
    import dbg_seq_pkg::*;
(
    input wire seq_state_t state,
    input wire logic [CODE_W-1:0] code,
    input wire logic [NCH-1:0] match,
    output seq_state_t next_state
);

    dest_t [NCH-1:0] dest;
    logic [NCH-1:0] hit;
    logic [NCH-1:0] hit_fin;

    function automatic seq_state_t to_state(input dest_t d, input seq_state_t cur);
        seq_state_t s;
        s = cur;
        if (d == D_S1) s = ST_ONE;
        else if (d == D_S2) s = ST_TWO;
        else if (d == D_S3) s = ST_THREE;
        else if (d == D_FIN) s = ST_FINAL;
        return s;
    endfunction

    // code tables, entries ordered {ch2, ch1, ch0}; unlisted codes go nowhere
    always_comb begin
        dest = {D_NONE, D_NONE, D_NONE};
        unique case (state)
            ST_ONE: begin
                case (code)
                    4'h0: dest = {D_FIN, D_FIN, D_FIN};
                    4'h1: dest = {D_NONE, D_S3, D_NONE};
                    4'h2: dest = {D_S2, D_NONE, D_NONE};
                    4'h3: dest = {D_NONE, D_S2, D_NONE};
                    4'h4: dest = {D_NONE, D_S3, D_S2};
                    4'h5: dest = {D_NONE, D_S3, D_FIN};
                    4'h6: dest = {D_S3, D_NONE, D_S2};
                    4'h7: dest = {D_NONE, D_S2, D_S2};
                    4'h9: dest = {D_NONE, D_NONE, D_S3};
                    4'hD: dest = {D_FIN, D_S2, D_FIN};
                    default: dest = {D_NONE, D_NONE, D_NONE};
                endcase
            end
            ST_TWO: begin
                case (code)
                    4'h0: dest = {D_S3, D_NONE, D_S1};
                    4'h1: dest = {D_NONE, D_S3, D_NONE};
                    4'h2: dest = {D_S3, D_NONE, D_NONE};
                    4'h3: dest = {D_NONE, D_S3, D_FIN};
                    4'h4: dest = {D_S3, D_S1, D_NONE};
                    4'h5: dest = {D_FIN, D_NONE, D_NONE};
                    4'h6: dest = {D_S1, D_NONE, D_FIN};
                    4'h7: dest = {D_NONE, D_FIN, D_FIN};
                    4'hC: dest = {D_S3, D_FIN, D_FIN};
                    4'hF: dest = {D_S1, D_FIN, D_FIN};
                    default: dest = {D_NONE, D_NONE, D_NONE};
                endcase
            end
            ST_THREE: begin
                case (code)
                    4'h0: dest = {D_NONE, D_NONE, D_S1};
                    4'h1: dest = {D_S2, D_FIN, D_NONE};
                    4'h2: dest = {D_NONE, D_S1, D_FIN};
                    4'h3: dest = {D_S1, D_FIN, D_NONE};
                    4'h4: dest = {D_NONE, D_S2, D_NONE};
                    4'h5: dest = {D_NONE, D_FIN, D_NONE};
                    4'h6: dest = {D_S2, D_NONE, D_FIN};
                    4'h7: dest = {D_NONE, D_NONE, D_FIN};
                    4'hA: dest = {D_S1, D_S1, D_FIN};
                    4'hD: dest = {D_FIN, D_FIN, D_S1};
                    4'hE: dest = {D_FIN, D_NONE, D_S2};
                    default: dest = {D_NONE, D_NONE, D_NONE};
                endcase
            end
            ST_IDLE, ST_FINAL: dest = {D_NONE, D_NONE, D_NONE};
        endcase
    end

    // per-channel qualified hits; an unnamed channel never hits
    genvar i;
    generate
        for (i = 0; i < NCH; i++) begin : g_hit
            assign hit[i] = match[i] && (dest[i] != D_NONE);
            assign hit_fin[i] = match[i] && (dest[i] == D_FIN);
        end
    endgenerate

    // final wins, then the lowest channel
    always_comb begin
        next_state = state;
        if (|hit_fin) next_state = ST_FINAL;
        else if (hit[0]) next_state = to_state(dest[0], state);
        else if (hit[1]) next_state = to_state(dest[1], state);
        else if (hit[2]) next_state = to_state(dest[2], state);
    end

endmodule

// [tb/match_source.sv]
/*
 * Comparator match channel model: match pulses asked for by the bench reach
 * the sequencer one pclk later, and only while the comparator enable is set.
 * Assumes the bench changes its requests right after rising pclk edges.
 */
`timescale 1ns/1ps
module match_source
    import dbg_seq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic comparator_enable,
    input wire logic [NCH-1:0] match_request,
    output logic [NCH-1:0] channel_match
);
    // a disabled comparator never raises a match event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_match <= '0;
        end else begin
            channel_match <= comparator_enable ? match_request : '0;
        end
    end
endmodule

// [tb/test_debug_state_sequencer.sv]
/*
 * Self-checking bench of the debug state sequencer: APB register map,
 * banked code registers, sticky flags and random match sessions.
 * Assumes the package, the design and the match channel model come first.
 */
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin errors++; \
    $display("FAIL %0t got %h exp %h", $time, (a), (e)); end end
module test_debug_state_sequencer
    import dbg_seq_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0, prdata, rd, tmp;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, session_armed, er, arm_e = 1'b0, en = 1'b1;
    logic [NCH-1:0] channel_match, match_flags, req = '0, xf = '0;
    seq_state_t seq_state;
    logic [31:0] x = 32'h61A0;
    logic [2:0] xi = 3'h0;
    logic [3:0] codes [3];
    int errors = 0, n_checks = 0, cyc = 0;
    // destination per channel, one nibble each: 1..3 state, 4 final
    logic [11:0] tbl [48] = '{
        12'h444, 12'h030, 12'h200, 12'h020, 12'h032, 12'h034, 12'h302, 12'h022,
        12'h000, 12'h003, 12'h000, 12'h000, 12'h000, 12'h424, 12'h000, 12'h000,
        12'h301, 12'h030, 12'h300, 12'h034, 12'h310, 12'h400, 12'h104, 12'h044,
        12'h000, 12'h000, 12'h000, 12'h000, 12'h344, 12'h000, 12'h000, 12'h144,
        12'h001, 12'h240, 12'h014, 12'h140, 12'h020, 12'h040, 12'h204, 12'h004,
        12'h000, 12'h000, 12'h114, 12'h000, 12'h000, 12'h441, 12'h402, 12'h000
    };
    seq_state_t st_map [5] = '{ST_IDLE, ST_ONE, ST_TWO, ST_THREE, ST_FINAL};

    initial begin
        forever #10 pclk = ~pclk;
    end

    debug_state_sequencer i_debug_state_sequencer (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .channel_match(channel_match), .seq_state(seq_state),
        .session_armed(session_armed), .match_flags(match_flags));
    match_source i_match_source (.pclk(pclk), .presetn(presetn), .comparator_enable(en),
        .match_request(req), .channel_match(channel_match));

    function automatic logic [31:0] rnd();
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    // lowest named channel moves, unless a matching one leads to final
    function automatic logic [2:0] next_i(input logic [2:0] cur, input logic [3:0] code,
                                          input logic [2:0] m);
        logic [11:0] t;
        logic [2:0] r;
        t = tbl[(int'(cur) - 1) * 16 + int'(code)];
        r = cur;
        for (int i = 2; i >= 0; i--) begin
            if (m[i] && t[4*i+:4] != 4'h0) begin
                r = t[4*i+:3];
            end
        end
        for (int i = 0; i < 3; i++) begin
            if (m[i] && t[4*i+:4] == 4'h4) begin
                r = 3'h4;
            end
        end
        return r;
    endfunction

    // one APB transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
        `CHK(er, (a != ADDR_CONTROL && a != ADDR_STATUS && a != ADDR_SHARED))
    endtask

    task automatic ctl(input logic a, input logic [1:0] w);
        wr(ADDR_CONTROL, {24'h0, a, 5'h0, w});
        arm_e = a;
    endtask

    task automatic arm(input logic [1:0] w);
        ctl(1'b1, w);
        xi = 3'h1;
        xf = 3'h0;
        #1;
        `CHK(seq_state, ST_ONE)
        `CHK(match_flags, FLAGS_RST)
    endtask

    // one match pulse, then the reference model moves and is compared
    task automatic step(input logic [2:0] m);
        logic [2:0] me;
        me = en ? m : 3'h0;
        req <= m;
        @(posedge pclk);
        req <= 3'h0;
        @(posedge pclk);
        if (arm_e && xi != 3'h0 && xi != 3'h4) begin
            xf = xf | me;
            xi = next_i(xi, codes[xi-1], me);
            arm_e = (xi != 3'h4);
        end
        #1;
        `CHK(seq_state, st_map[xi])
        `CHK(match_flags, xf)
        `CHK(session_armed, arm_e)
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            $display("FAIL %0t timeout", $time);
            print_verdict();
        end
    end

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, unmapped and read-only places, ignored strobe
        rdchk(ADDR_CONTROL, 32'h0);
        rdchk(ADDR_STATUS, {27'h0, ST_IDLE});
        rdchk(ADDR_SHARED, {28'h0, CODE_RST});
        rdchk(12'hFF0, 32'h0);
        `CHK(er, 1'b1)
        wr(ADDR_STATUS, 32'hFF);
        rdchk(ADDR_STATUS, {27'h0, ST_IDLE});
        pstrb <= 4'h0;
        wr(ADDR_SHARED, 32'h5);
        pstrb <= 4'hF;
        rdchk(ADDR_SHARED, 32'h0);
        // sessions: every code in turn first, random codes after
        for (int it = 0; it < 40; it++) begin
            en <= (it % 8) != 7;
            for (int s = 0; s < 3; s++) begin
                tmp = rnd();
                codes[s] = (it < 16) ? 4'(it) : tmp[3:0];
                ctl(1'b0, 2'(s));
                wr(ADDR_SHARED, {tmp[31:4], codes[s]});
                rdchk(ADDR_SHARED, {28'h0, codes[s]});
            end
            arm(WIN_SCR1);
            wr(ADDR_SHARED, {28'h0, ~codes[0]});
            for (int k = 0; k < 8; k++) begin
                tmp = rnd();
                step((it < 16 && k == 0) ? 3'h3 : tmp[2:0]);
            end
            ctl(1'b0, WIN_FLAGS);
            rdchk(ADDR_SHARED, {29'h0, xf});
            wr(ADDR_SHARED, 32'h7);
            rdchk(ADDR_SHARED, {29'h0, xf});
            rdchk(ADDR_STATUS, {27'h0, st_map[xi]});
            ctl(1'b0, WIN_SCR1);
            rdchk(ADDR_SHARED, {28'h0, codes[0]});
        end
        // mid-run reset brings every register back to its reset value
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(ADDR_CONTROL, 32'h0);
        rdchk(ADDR_SHARED, {28'h0, CODE_RST});
        rdchk(ADDR_STATUS, {27'h0, ST_IDLE});
        `CHK(match_flags, FLAGS_RST)
        print_verdict();
    end
endmodule
